// File: rtl/msc_serial_controller.v
// Controller-mode serial port fed from a grouped multibuffer memory
//
// What this block does
// R1: Buffer memory holds 256 transfer entries.
// R2: Entry has transmit, receive, control, status fields.
// R3: Memory split into groups of consecutive entries.
// R4: Prescale N gives N+1 cycles; zero gives two.
// R5: Serial clock period must stay at least 25 ns; a shorter period is only flagged on PRESCALE_TOO_FAST.
// R6: Mode bit 0 selects controller; phase 0 only.
// R7: Polarity bit sets idle level and active edge.
// R8: Serial clock high and low halves equal; an odd period gives the active half one more cycle.
// R9: Data bit leads its active edge half period.
// R10: Select leads first edge by setup plus 2.
// R11: With hold option, lead is setup plus 3.
// R12: Select releases half period plus hold plus 1.
// R13: Setup and hold counts come from delay register.
// R14: Word length 2 to 16, per word.
// R15: Incoming data sampled on the active edge.
// R16: Peripheral keeps data stable at sampling edge.
`timescale 1ns/10ps
`include "msc_regs.vh"

module msc_serial_controller (
   input  wire                         REF_CLK,
   input  wire                         RESETN,
   input  wire [0:0]                   GLOBAL_CONTROL_REGISTER,
   input  wire [`MSC_FMT_W-1:0]        WORD_FORMAT_REGISTER,
   input  wire [15:0]                  SELECT_DELAY_REGISTER,
   input  wire                         SELECT_HOLD_OPTION,
   input  wire [8*`MSC_GROUPS-1:0]     GROUP_FIRST,
   input  wire [8*`MSC_GROUPS-1:0]     GROUP_LAST,
   input  wire [`MSC_GROUPS-1:0]       GROUP_TRIGGER,
   input  wire [`MSC_ADDR_W-1:0]       RAM_ADDR,
   input  wire [`MSC_FIELDS-1:0]       RAM_WRITE_EN,
   input  wire [`MSC_ENTRY_W-1:0]      RAM_WRITE_DATA,
   output wire [`MSC_ENTRY_W-1:0]      RAM_READ_DATA,
   output wire                         SERIAL_CLOCK_LINE,
   output wire                         CONTROLLER_OUT_LINE,
   input  wire                         CONTROLLER_IN_LINE,
   output wire                         CHIP_SELECT_N,
   output wire                         BUSY,
   output wire [`MSC_GROUPS-1:0]       GROUP_DONE,
   output wire [1:0]                   ACTIVE_GROUP,
   output wire                         PRESCALE_TOO_FAST
);
   localparam ST_IDLE  = 3'h0;
   localparam ST_FETCH = 3'h1;
   localparam ST_LOAD  = 3'h2;
   localparam ST_SETUP = 3'h3;
   localparam ST_SHIFT = 3'h4;
   localparam ST_HOLD  = 3'h5;
   localparam ST_STORE = 3'h6;

   reg  [2:0]                  state_reg;
   reg  [9:0]                  cnt_reg;
   reg                         sclk_reg;
   reg                         cs_n_reg;
   reg                         dout_reg;
   reg  [15:0]                 shift_reg;
   reg  [15:0]                 rx_reg;
   reg  [4:0]                  bits_reg;
   reg  [4:0]                  len_reg;
   reg                         active_half_reg;
   reg  [`MSC_ADDR_W-1:0]      ptr_reg;
   reg  [`MSC_ADDR_W-1:0]      last_reg;
   reg  [1:0]                  grp_reg;
   reg  [`MSC_GROUPS-1:0]      done_reg;
   reg  [`MSC_GROUPS-1:0]      pending_reg;
   reg                         too_fast_reg;

   wire [`MSC_ENTRY_W-1:0]     eng_rdata;
   wire [`MSC_ENTRY_W-1:0]     eng_wdata;
   wire [`MSC_FIELDS-1:0]      eng_we;

   wire [7:0] prescale = WORD_FORMAT_REGISTER[`MSC_FMT_PS_MSB:`MSC_FMT_PS_LSB];
   wire       pol      = WORD_FORMAT_REGISTER[`MSC_FMT_POL_BIT];
   wire       phase    = WORD_FORMAT_REGISTER[`MSC_FMT_PHASE_BIT];
   wire [7:0] setup_dly = SELECT_DELAY_REGISTER[`MSC_DLY_SETUP_MSB:`MSC_DLY_SETUP_LSB]; // R13
   wire [7:0] hold_dly  = SELECT_DELAY_REGISTER[`MSC_DLY_HOLD_MSB:`MSC_DLY_HOLD_LSB];   // R13

   // Phase 1 timing is not built here, so that setting keeps the engine parked
   wire mode_ok = GLOBAL_CONTROL_REGISTER[`MSC_GCR_MODE_BIT] & ~phase; // R6

   // Serial clock period in bus clock cycles
   wire [8:0] period  = (prescale == 8'h00) ? `MSC_PERIOD_PS0
                                            : ({1'b0, prescale} + 9'h001); // R4
   // Odd periods give the extra cycle to the active half
   wire [7:0] half_lo = period[8:1]; // R8
   wire [8:0] half_hi = period - {1'b0, half_lo}; // R8

   wire [9:0] setup_cnt = {2'b00, setup_dly}
                        + (SELECT_HOLD_OPTION ? `MSC_SETUP_EXTRA_HOLD : `MSC_SETUP_EXTRA)
                        - 10'h001; // R10 R11
   wire [9:0] hold_cnt  = {2'b00, half_lo} + {2'b00, hold_dly} + `MSC_HOLD_EXTRA
                        - 10'h001; // R12
   wire [9:0] hi_cnt    = {1'b0, half_hi} - 10'h001;
   wire [9:0] lo_cnt    = {2'b00, half_lo} - 10'h001;

   // One shared down-counter paces setup, both clock halves and the hold wait
   wire       cnt_zero  = (cnt_reg == 10'h000);
   wire [9:0] cnt_dec   = cnt_reg - 10'h001;

   // Word length from the entry's own control field, clamped to the legal span
   wire [4:0] ctrl_len = eng_rdata[`MSC_CTRL_LSB+`MSC_CTRL_LEN_MSB:
                                   `MSC_CTRL_LSB+`MSC_CTRL_LEN_LSB];
   wire [4:0] len_eff  = (ctrl_len < `MSC_LEN_MIN) ? `MSC_LEN_MIN :
                         (ctrl_len > `MSC_LEN_MAX) ? `MSC_LEN_MAX : ctrl_len; // R14
   wire [4:0] pad      = `MSC_LEN_MAX - len_eff;
   wire [15:0] tx_word = eng_rdata[`MSC_TX_LSB +: `MSC_FIELD_W];
   wire [15:0] tx_aligned = tx_word << pad; // R14

   // Lowest-numbered pending group is served first
   reg  [1:0]                  sel_idx;
   integer                     i;
   always @* begin
      sel_idx = 2'h0;
      for (i = `MSC_GROUPS - 1; i >= 0; i = i - 1) begin
         if (pending_reg[i]) begin
            sel_idx = i[1:0];
         end
      end
   end
   wire       sel_found = |pending_reg;
   wire [7:0] sel_first = GROUP_FIRST[{sel_idx, 3'h0} +: 8]; // R3
   wire [7:0] sel_last  = GROUP_LAST[{sel_idx, 3'h0} +: 8];  // R3
   // Group bounds are read only as the group starts

   // Starting a group clears its request; a trigger on that same edge is kept,
   // so software can queue a rerun while the group is still busy
   wire       start_run = (state_reg == ST_IDLE) && mode_ok && sel_found; // R6
   wire [`MSC_GROUPS-1:0] start_hot = start_run ? (4'h1 << sel_idx) : 4'h0;
   genvar g;
   generate
      for (g = 0; g < `MSC_GROUPS; g = g + 1) begin : g_pend
         always @(posedge REF_CLK or negedge RESETN) begin
            if (!RESETN) begin
               pending_reg[g] <= 1'b0;
            end else begin
               pending_reg[g] <= GROUP_TRIGGER[g] | (pending_reg[g] & ~start_hot[g]); // R3
            end
         end
      end
   endgenerate

   // Flags a prescale that breaks the minimum serial clock period
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         too_fast_reg <= 1'b0;
      end else begin
         too_fast_reg <= (period < `MSC_SCLK_MIN_CYC); // R5
      end
   end

   // End-of-word decisions; with the hold option select stays low between the
   // words of a group and only the group's last word pays the hold wait
   wire       last_bit   = (bits_reg == 5'h01);
   wire       last_entry = (ptr_reg == last_reg);
   wire       chain_word = SELECT_HOLD_OPTION && !last_entry;

   // Transfer engine: one word per pass from FETCH to STORE
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_reg       <= ST_IDLE;
         cnt_reg         <= 10'h000;
         sclk_reg        <= 1'b0;
         cs_n_reg        <= 1'b1;
         dout_reg        <= 1'b0;
         shift_reg       <= 16'h0000;
         rx_reg          <= 16'h0000;
         bits_reg        <= 5'h00;
         len_reg         <= 5'h00;
         active_half_reg <= 1'b0;
         ptr_reg         <= 8'h00;
         last_reg        <= 8'h00;
         grp_reg         <= 2'h0;
         done_reg        <= 4'h0;
      end else begin
         done_reg <= 4'h0;
         case (state_reg)
            ST_IDLE: begin
               // Clock follows polarity here so a change settles before select falls
               sclk_reg <= pol; // R7
               cs_n_reg <= 1'b1;
               if (start_run) begin // R6
                  grp_reg   <= sel_idx;
                  ptr_reg   <= sel_first;
                  last_reg  <= sel_last;
                  state_reg <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               // Buffer read is registered, so the entry shows up a cycle later
               state_reg <= ST_LOAD;
            end
            ST_LOAD: begin
               // First bit goes out now, well ahead of the first active edge
               shift_reg <= tx_aligned;
               dout_reg  <= tx_aligned[15]; // R9
               bits_reg  <= len_eff;
               len_reg   <= len_eff;
               rx_reg    <= 16'h0000;
               if (cs_n_reg) begin
                  cs_n_reg <= 1'b0;
                  cnt_reg  <= setup_cnt; // R10 R11
               end else begin
                  cnt_reg  <= lo_cnt;
               end
               state_reg <= ST_SETUP;
            end
            ST_SETUP: begin
               // First active edge; the first bit has been out since LOAD
               if (!cnt_zero) begin
                  cnt_reg <= cnt_dec;
               end else begin
                  sclk_reg        <= ~pol; // R7
                  rx_reg          <= {rx_reg[14:0], CONTROLLER_IN_LINE}; // R15
                  cnt_reg         <= hi_cnt;
                  active_half_reg <= 1'b1;
                  state_reg       <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (!cnt_zero) begin
                  cnt_reg <= cnt_dec;
               end else if (active_half_reg) begin
                  sclk_reg <= pol; // R8
                  // Last bit: the trailing edge returns the clock to idle level
                  if (last_bit) begin
                     if (chain_word) begin
                        state_reg <= ST_STORE;
                     end else begin
                        cnt_reg   <= hold_cnt; // R12
                        state_reg <= ST_HOLD;
                     end
                  end else begin
                     // Outgoing data changes on the trailing edge
                     bits_reg        <= bits_reg - 5'h01;
                     shift_reg       <= {shift_reg[14:0], 1'b0};
                     dout_reg        <= shift_reg[14]; // R9
                     cnt_reg         <= lo_cnt; // R8
                     active_half_reg <= 1'b0;
                  end
               end else begin
                  sclk_reg        <= ~pol; // R7
                  rx_reg          <= {rx_reg[14:0], CONTROLLER_IN_LINE}; // R15 R16
                  cnt_reg         <= hi_cnt; // R8
                  active_half_reg <= 1'b1;
               end
            end
            ST_HOLD: begin
               // Select stays low until the peripheral has seen the last edge settle
               if (!cnt_zero) begin
                  cnt_reg <= cnt_dec;
               end else begin
                  cs_n_reg  <= 1'b1; // R12
                  state_reg <= ST_STORE;
               end
            end
            ST_STORE: begin
               // Receive and status land now; the next entry is fetched after this
               if (last_entry) begin
                  done_reg[grp_reg] <= 1'b1;
                  state_reg         <= ST_IDLE;
               end else begin
                  ptr_reg   <= ptr_reg + 8'h01; // R3
                  state_reg <= ST_FETCH;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Receive and status fields are written back as the word retires
   assign eng_we    = (state_reg == ST_STORE) ? `MSC_WE_STORE : 4'h0;
   // Status reports completion in bit 0 and the length actually shifted
   wire [15:0] status_word = {3'h0, len_reg, 7'h00, 1'b1}; // R2
   assign eng_wdata = {status_word, 16'h0000, rx_reg, 16'h0000}; // R2

   msc_buffer_ram u_ram (
      .clk     (REF_CLK),
      .a_addr  (RAM_ADDR),
      .a_we    (RAM_WRITE_EN),
      .a_wdata (RAM_WRITE_DATA),
      .a_rdata (RAM_READ_DATA),
      .b_addr  (ptr_reg),
      .b_we    (eng_we),
      .b_wdata (eng_wdata),
      .b_rdata (eng_rdata)
   );

   // Pins come straight from flip-flops; only BUSY is decoded from the state
   assign SERIAL_CLOCK_LINE   = sclk_reg;
   assign CONTROLLER_OUT_LINE = dout_reg;
   assign CHIP_SELECT_N       = cs_n_reg;
   assign BUSY                = (state_reg != ST_IDLE);
   assign GROUP_DONE          = done_reg;
   assign ACTIVE_GROUP        = grp_reg;
   assign PRESCALE_TOO_FAST   = too_fast_reg;
endmodule // msc_serial_controller

// File: rtl/msc_regs.vh
// Constants for the multibuffer serial controller
`ifndef MSC_REGS_VH
`define MSC_REGS_VH

`define MSC_ENTRIES          256
`define MSC_ADDR_W           8
`define MSC_ENTRY_W          64
`define MSC_FIELDS           4
`define MSC_FIELD_W          16
`define MSC_GROUPS           4

`define MSC_TX_LSB           0
`define MSC_RX_LSB           16
`define MSC_CTRL_LSB         32
`define MSC_STAT_LSB         48
`define MSC_WE_STORE         4'hA

`define MSC_GCR_MODE_BIT     0
`define MSC_FMT_PS_MSB       15
`define MSC_FMT_PS_LSB       8
`define MSC_FMT_PHASE_BIT    16
`define MSC_FMT_POL_BIT      17
`define MSC_FMT_W            18
`define MSC_DLY_SETUP_MSB    15
`define MSC_DLY_SETUP_LSB    8
`define MSC_DLY_HOLD_MSB     7
`define MSC_DLY_HOLD_LSB     0
`define MSC_CTRL_LEN_MSB     4
`define MSC_CTRL_LEN_LSB     0
`define MSC_STAT_DONE_BIT    0
`define MSC_STAT_LEN_LSB     8

`define MSC_LEN_MIN          5'h02
`define MSC_LEN_MAX          5'h10
`define MSC_PERIOD_PS0       9'h002
`define MSC_SETUP_EXTRA      10'h002
`define MSC_SETUP_EXTRA_HOLD 10'h003
`define MSC_HOLD_EXTRA       10'h001

`define MSC_CLK_PERIOD_NS    10
`define MSC_SCLK_MIN_NS      25
`define MSC_SCLK_MIN_CYC     ((`MSC_SCLK_MIN_NS + `MSC_CLK_PERIOD_NS - 1) / `MSC_CLK_PERIOD_NS)

`endif

// File: rtl/msc_buffer_ram.v
// Two-port buffer memory with per-field write enables and registered reads
`timescale 1ns/10ps
`include "msc_regs.vh"

module msc_buffer_ram (
   input  wire                       clk,
   input  wire [`MSC_ADDR_W-1:0]     a_addr,
   input  wire [`MSC_FIELDS-1:0]     a_we,
   input  wire [`MSC_ENTRY_W-1:0]    a_wdata,
   output reg  [`MSC_ENTRY_W-1:0]    a_rdata,
   input  wire [`MSC_ADDR_W-1:0]     b_addr,
   input  wire [`MSC_FIELDS-1:0]     b_we,
   input  wire [`MSC_ENTRY_W-1:0]    b_wdata,
   output reg  [`MSC_ENTRY_W-1:0]    b_rdata
);
   reg [`MSC_ENTRY_W-1:0] mem [0:`MSC_ENTRIES-1]; // R1

   // Port b is written after port a, so it wins a same-field collision
   genvar f;
   generate
      for (f = 0; f < `MSC_FIELDS; f = f + 1) begin : g_field
         always @(posedge clk) begin
            if (a_we[f]) begin
               mem[a_addr][f*`MSC_FIELD_W +: `MSC_FIELD_W] <=
                  a_wdata[f*`MSC_FIELD_W +: `MSC_FIELD_W]; // R2
            end
            if (b_we[f]) begin
               mem[b_addr][f*`MSC_FIELD_W +: `MSC_FIELD_W] <=
                  b_wdata[f*`MSC_FIELD_W +: `MSC_FIELD_W]; // R2
            end
         end
      end
   endgenerate

   always @(posedge clk) begin
      a_rdata <= mem[a_addr];
      b_rdata <= mem[b_addr];
   end
endmodule // msc_buffer_ram

// File: sim/msc_checker_sva.sv
// Pin-level assertions for the serial controller
`timescale 1ns/10ps
`include "msc_regs.vh"

module msc_checker_sva (
   input wire        REF_CLK,
   input wire        RESETN,
   input wire [17:0] WORD_FORMAT_REGISTER,
   input wire [15:0] SELECT_DELAY_REGISTER,
   input wire        SELECT_HOLD_OPTION,
   input wire        SERIAL_CLOCK_LINE,
   input wire        CONTROLLER_OUT_LINE,
   input wire        CHIP_SELECT_N,
   input wire        BUSY,
   input wire [3:0]  GROUP_DONE,
   input wire        PRESCALE_TOO_FAST
);
   wire        pol = WORD_FORMAT_REGISTER[17];
   wire        sc = SERIAL_CLOCK_LINE;
   wire        csn = CHIP_SELECT_N;
   wire [7:0]  ps = WORD_FORMAT_REGISTER[15:8];
   wire [15:0] per = (ps == 8'h00) ? 16'h0002 : {8'h00, ps} + 16'h0001;
   wire [15:0] hlf = per >> 1;
   wire [15:0] setup = {8'h00, SELECT_DELAY_REGISTER[15:8]};
   wire [15:0] hold = {8'h00, SELECT_DELAY_REGISTER[7:0]};
   wire        fast_exp = per < 16'h0003;
   reg  [15:0] lead;
   reg  [15:0] gap;
   reg         armed;
   // Counters restart at 2 so they read cycles since the pin moved, as seen one edge late
   always @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         lead <= 16'h0000;
         gap <= 16'h0000;
         armed <= 1'b0;
      end else begin
         lead <= $fell(csn) ? 16'h0002 : lead + 16'h0001;
         gap <= $changed(sc) ? 16'h0002 : gap + 16'h0001;
         armed <= $fell(csn) | (armed & !$changed(sc));
      end
   end
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);
   sequence idle_pair;
      !BUSY ##1 (!BUSY && $stable(pol));
   endsequence
   sequence first_edge;
      armed && $changed(sc);
   endsequence
   idle_level_a: assert property (idle_pair |-> sc == pol)
      else $error("serial clock off its idle level");
   select_idle_a: assert property (!BUSY |-> csn)
      else $error("select low while idle");
   clock_framed_a: assert property ($changed(sc) && BUSY |-> !csn)
      else $error("serial clock moved outside select");
   setup_plain_a: assert property (first_edge ##0 !SELECT_HOLD_OPTION |-> lead == setup + 3)
      else $error("select lead wrong");
   setup_hold_a: assert property (first_edge ##0 SELECT_HOLD_OPTION |-> lead == setup + 4)
      else $error("select lead wrong with hold option");
   release_gap_a: assert property ($rose(csn) |-> gap == hlf + hold + 16'h0002)
      else $error("select release gap wrong");
   active_half_a: assert property ($changed(sc) && sc == pol && !csn |-> gap == per - hlf + 1)
      else $error("active half length wrong");
   idle_half_a: assert property ($changed(sc) && sc != pol && !csn && !armed
      && !SELECT_HOLD_OPTION |-> gap == hlf + 16'h0001)
      else $error("inactive half length wrong");
   data_trailing_a: assert property ($changed(CONTROLLER_OUT_LINE) && !csn && !$fell(csn)
      && !SELECT_HOLD_OPTION |-> $changed(sc) && sc == pol)
      else $error("data moved off the trailing edge");
   done_pulse_a: assert property (GROUP_DONE != 4'h0 |=> GROUP_DONE == 4'h0)
      else $error("group done longer than one cycle");
   too_fast_a: assert property (1'b1 |=> PRESCALE_TOO_FAST == $past(fast_exp))
      else $error("too fast flag wrong");
endmodule // msc_checker_sva

bind msc_serial_controller msc_checker_sva chk (.REF_CLK(REF_CLK), .RESETN(RESETN),
   .WORD_FORMAT_REGISTER(WORD_FORMAT_REGISTER), .SELECT_DELAY_REGISTER(SELECT_DELAY_REGISTER),
   .SELECT_HOLD_OPTION(SELECT_HOLD_OPTION), .SERIAL_CLOCK_LINE(SERIAL_CLOCK_LINE),
   .CONTROLLER_OUT_LINE(CONTROLLER_OUT_LINE), .CHIP_SELECT_N(CHIP_SELECT_N), .BUSY(BUSY),
   .GROUP_DONE(GROUP_DONE), .PRESCALE_TOO_FAST(PRESCALE_TOO_FAST));

// File: sim/msc_peripheral_model.sv
// Behavioural serial peripheral on the far side of the controller
`timescale 1ns/10ps

module msc_peripheral_model (
   input  wire        sclk,
   input  wire        cs_n,
   input  wire        mosi,
   input  wire        pol,
   input  wire [15:0] reply,
   output reg         miso,
   output reg  [15:0] got
);
   integer idx;
   initial begin
      miso = 1'b0;
      got = 16'h0000;
      idx = 15;
   end
   // Released line shows the inverse of its last bit so a held value cannot pass
   always @(posedge cs_n) miso = ~miso;
   always @(negedge cs_n) begin
      idx = 15;
      miso = reply[15];
   end
   // Reply index wraps every 16 bits, so held-select words continue the pattern
   always @(sclk) begin
      if (!cs_n && sclk != pol) got = {got[14:0], mosi};
      else if (!cs_n) begin
         idx = idx - 1;
         miso = reply[idx[3:0]];
      end
   end
endmodule // msc_peripheral_model

// File: sim/msc_serial_controller_bench.sv
// Self-checking bench for the multibuffer serial controller
`timescale 1ns/10ps

module msc_serial_controller_bench;
   localparam [15:0] REPLY = 16'hB3C5;
   reg         clk = 1'b0;
   reg         rst_n = 1'b0;
   reg  [0:0]  gcr = 1'b1;
   reg  [17:0] fmt = 18'h00100;
   reg  [15:0] dly = 16'h0000;
   reg         hopt = 1'b0;
   reg  [31:0] gf = 32'h0;
   reg  [31:0] gl = 32'h0;
   reg  [3:0]  trig = 4'h0;
   reg  [7:0]  addr = 8'h00;
   reg  [3:0]  we = 4'h0;
   reg  [63:0] wd = 64'h0;
   reg  [63:0] rd;
   wire [63:0] rdata;
   wire        sclk, mosi, miso, cs_n, busy, fast;
   wire [3:0]  done;
   wire [1:0]  grp;
   wire [15:0] got;
   integer     n_errors = 0;
   integer     checks_done = 0;
   integer     i;
   always #5 clk = ~clk;
   msc_serial_controller dut (.REF_CLK(clk), .RESETN(rst_n), .GLOBAL_CONTROL_REGISTER(gcr),
      .WORD_FORMAT_REGISTER(fmt), .SELECT_DELAY_REGISTER(dly), .SELECT_HOLD_OPTION(hopt),
      .GROUP_FIRST(gf), .GROUP_LAST(gl), .GROUP_TRIGGER(trig), .RAM_ADDR(addr),
      .RAM_WRITE_EN(we), .RAM_WRITE_DATA(wd), .RAM_READ_DATA(rdata),
      .SERIAL_CLOCK_LINE(sclk), .CONTROLLER_OUT_LINE(mosi), .CONTROLLER_IN_LINE(miso),
      .CHIP_SELECT_N(cs_n), .BUSY(busy), .GROUP_DONE(done), .ACTIVE_GROUP(grp),
      .PRESCALE_TOO_FAST(fast));
   msc_peripheral_model peer (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .pol(fmt[17]),
      .reply(REPLY), .miso(miso), .got(got));
   task check(input string what, input [63:0] seen, input [63:0] expv);
      begin
         checks_done = checks_done + 1;
         if (seen !== expv) begin
            n_errors = n_errors + 1;
            $display("ERROR %s expected %h seen %h", what, expv, seen);
         end
      end
   endtask
   task tick(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   task wr(input [7:0] a, input [3:0] w, input [63:0] d);
      begin
         addr = a;
         we = w;
         wd = d;
         tick(1);
         we = 4'h0;
         tick(1);
      end
   endtask
   task get(input [7:0] a);
      begin
         addr = a;
         tick(1);
         rd = rdata;
      end
   endtask
   task entry(input [7:0] a, input [4:0] len);
      begin
         get(a);
         check("rx field", rd[31:16], REPLY >> (16 - len));
         check("status field", rd[63:48], {3'h0, len, 7'h00, 1'b1});
      end
   endtask
   task fire(input [1:0] g, input [7:0] f, input [7:0] l);
      begin
         gf[8*g +: 8] = f;
         gl[8*g +: 8] = l;
         trig[g] = 1'b1;
         tick(1);
         trig = 4'h0;
      end
   endtask
   task wait_done(input [1:0] g);
      begin
         for (i = 0; i < 3000 && done[g] !== 1'b1; i = i + 1) tick(1);
         check("group done", done[g], 1'b1);
         check("active group", grp, g);
         tick(1);
         check("busy after group", busy, 1'b0);
      end
   endtask
   task t_memory;
      begin
         wr(8'hFF, 4'hF, 64'h1234_5678_9ABC_DEF0);
         wr(8'h00, 4'hF, 64'hFFFF_FFFF_FFFF_FFFF);
         get(8'hFF);
         check("entry 255", rd, 64'h1234_5678_9ABC_DEF0);
         wr(8'hFF, 4'h8, 64'hA5A5_0000_0000_0000);
         get(8'hFF);
         check("status write", rd, 64'hA5A5_5678_9ABC_DEF0);
      end
   endtask
   // Length code 1 clamps to the two-bit minimum
   task t_plain;
      begin
         wr(8'h00, 4'h5, {27'h0, 5'h01, 16'h0, 16'h0002});
         check("too fast", fast, 1'b1);
         fire(2'h0, 8'h00, 8'h00);
         wait_done(2'h0);
         check("out bits", got[1:0], 2'h2);
         entry(8'h00, 5'h02);
      end
   endtask
   task t_polarity;
      begin
         fmt = 18'h20400;
         dly = 16'h0302;
         wr(8'hFF, 4'h5, {27'h0, 5'h1F, 16'h0, 16'hC3A5});
         check("slow enough", fast, 1'b0);
         check("clock idle high", sclk, 1'b1);
         fire(2'h1, 8'hFF, 8'hFF);
         wait_done(2'h1);
         check("out word", got, 16'hC3A5);
         entry(8'hFF, 5'h10);
      end
   endtask
   task t_hold;
      begin
         fmt = 18'h00000;
         dly = 16'h0100;
         hopt = 1'b1;
         wr(8'h0A, 4'h5, {27'h0, 5'h10, 16'h0, 16'h1111});
         wr(8'h0B, 4'h5, {27'h0, 5'h10, 16'h0, 16'h2222});
         wr(8'h0C, 4'h5, {27'h0, 5'h04, 16'h0, 16'h0009});
         fire(2'h2, 8'h0A, 8'h0C);
         wait_done(2'h2);
         check("last word", got[3:0], 4'h9);
         entry(8'h0A, 5'h10);
         entry(8'h0B, 5'h10);
         entry(8'h0C, 5'h04);
         hopt = 1'b0;
      end
   endtask
   task t_refused;
      begin
         fmt = 18'h10100;
         wr(8'h14, 4'h5, {27'h0, 5'h08, 16'h0, 16'h005A});
         fire(2'h3, 8'h14, 8'h14);
         tick(20);
         check("phase one idle", busy, 1'b0);
         gcr = 1'b0;
         fmt = 18'h00100;
         tick(20);
         check("mode off idle", busy, 1'b0);
         gcr = 1'b1;
         wait_done(2'h3);
         check("pending word", got[7:0], 8'h5A);
         entry(8'h14, 5'h08);
      end
   endtask
   task tally_and_finish;
      begin
         $display("errors %0d checks %0d", n_errors, checks_done);
         if (n_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   initial begin
      repeat (16) @(posedge clk);
      #1;
      rst_n = 1'b1;
      tick(1);
      check("select idle", cs_n, 1'b1);
      check("clock idle", sclk, 1'b0);
      t_memory;
      t_plain;
      t_polarity;
      t_hold;
      t_refused;
      tally_and_finish;
   end
   // Whole run needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_errors = n_errors + 1;
      tally_and_finish;
   end
endmodule // msc_serial_controller_bench
